// File: cmu_assertions.sv
// Checker of the instruction and write-back ports of the conditional move unit.
// Assumes it is bound to cmu_top and sees only that module's ports.
module cmu_assertions #(
  parameter GPR_W = 32,
  parameter FPR_W = 64,
  parameter CC_N = 8
) (
  input wire REF_CLK,
  input wire RSTN,
  input wire INSTR_VALID,
  input wire [31:0] INSTR,
  input wire [GPR_W-1:0] GPR_SRC_DATA,
  input wire [GPR_W-1:0] GPR_TEST_DATA,
  input wire [FPR_W-1:0] FPR_SRC_DATA,
  input wire [FPR_W-1:0] FPR_DEST_DATA,
  input wire [CC_N-1:0] FP_COND_CODES,
  input wire GPR_WR_EN,
  input wire [4:0] GPR_WR_ADDR,
  input wire [GPR_W-1:0] GPR_WR_DATA,
  input wire FPR_WR_EN,
  input wire [FPR_W-1:0] FPR_WR_DATA,
  input wire EXC_VALID,
  input wire [1:0] EXC_CODE
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  wire spc = INSTR_VALID && INSTR[31:26] == 6'h00;
  wire i_cm = spc && INSTR[5:0] == 6'h01;
  wire i_mz = spc && INSTR[5:0] == 6'h0A && INSTR[10:6] == 5'h00;
  wire fpm = INSTR_VALID && INSTR[31:26] == 6'h11;
  wire cc_hit = FP_COND_CODES[INSTR[20:18]] == INSTR[16];
  wire t_zero = GPR_TEST_DATA == 0;
  wire [31:0] lo_pick = cc_hit ? FPR_SRC_DATA[31:0] : FPR_DEST_DATA[31:0];
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_zero_copies: assert property (
    i_mz && t_zero |=> GPR_WR_EN && GPR_WR_DATA == $past(GPR_SRC_DATA))
    else $error("zero move did not copy");
  a_zero_blocks: assert property (
    i_mz && !t_zero |=> !GPR_WR_EN) else $error("zero move wrote on nonzero test");
  a_cond_blocks: assert property (
    i_cm && !INSTR[17] && !cc_hit |=> !GPR_WR_EN) else $error("cond move wrote on miss");
  a_bad_field: assert property (
    i_cm && INSTR[17] |=> EXC_VALID && !GPR_WR_EN && (EXC_CODE == 2'h1 || EXC_CODE == 2'h2))
    else $error("bad cond move not refused");
  a_wr_addr: assert property (
    GPR_WR_EN |-> $past(INSTR_VALID) && GPR_WR_ADDR == $past(INSTR[15:11]))
    else $error("integer write address wrong");
  a_fzero_hold: assert property (
    fpm && INSTR[5:0] == 6'h12 && !t_zero |=> !FPR_WR_EN || FPR_WR_DATA == $past(FPR_DEST_DATA))
    else $error("float zero move lost destination");
  a_fnz_copy: assert property (
    fpm && INSTR[5:0] == 6'h13 && !t_zero |=> !FPR_WR_EN || FPR_WR_DATA == $past(FPR_SRC_DATA))
    else $error("float nonzero move did not copy");
  a_low_half: assert property (
    fpm && INSTR[5:0] == 6'h11 && INSTR[25:21] == 5'h16
    |=> !FPR_WR_EN || FPR_WR_DATA[31:0] == $past(lo_pick)) else $error("paired low half wrong");
  a_exc_alone: assert property (
    EXC_VALID |-> !GPR_WR_EN && !FPR_WR_EN && EXC_CODE != 2'h0)
    else $error("exception with write or no code");
  c_zero: cover property (i_mz && t_zero);
  c_paired: cover property (fpm && INSTR[25:21] == 5'h16);
  c_exc: cover property (EXC_VALID);
endmodule

// File: cmu_consts.vh
// Constants of the conditional move unit: opcodes, fields, registers.
// Assumes inclusion by bare name from every design file of the unit.
`ifndef CMU_CONSTS_VH
`define CMU_CONSTS_VH

// ---------------------------------------------------------------
// Instruction fields
// ---------------------------------------------------------------
`define CMU_OP_HI 31
`define CMU_OP_LO 26
`define CMU_SRC_HI 25
`define CMU_SRC_LO 21
`define CMU_TEST_HI 20
`define CMU_TEST_LO 16
`define CMU_CC_HI 20
`define CMU_CC_LO 18
`define CMU_CC_ZERO_BIT 17
`define CMU_TF_BIT 16
`define CMU_DEST_HI 15
`define CMU_DEST_LO 11
`define CMU_SA_HI 10
`define CMU_SA_LO 6
`define CMU_FUNC_HI 5
`define CMU_FUNC_LO 0

// ---------------------------------------------------------------
// Opcode and function values
// ---------------------------------------------------------------
`define CMU_OP_SPECIAL 6'h00
`define CMU_OP_COP1 6'h11
`define CMU_FN_CONDMOVE 6'h01
`define CMU_FN_MOVE_ZERO 6'h0A
`define CMU_FN_MOVE_NONZERO 6'h0B
`define CMU_FFN_CONDMOVE 6'h11
`define CMU_FFN_MOVE_ZERO 6'h12
`define CMU_FFN_MOVE_NONZERO 6'h13
`define CMU_FMT_SINGLE 5'h10
`define CMU_FMT_DOUBLE 5'h11
`define CMU_FMT_PAIRED 5'h16
`define CMU_SA_ZERO 5'h00

// ---------------------------------------------------------------
// Register map (byte addresses) and fields
// ---------------------------------------------------------------
`define CMU_REG_CTRL 12'h000
`define CMU_REG_STATUS 12'h004
`define CMU_REG_MASK 12'h008
`define CMU_REG_COUNT 12'h00C
`define CMU_CTRL_FPU_USABLE 0
`define CMU_CTRL_FR16_MODE 1
`define CMU_CTRL_RESET 32'h00000001
`define CMU_EVT_RESERVED 0
`define CMU_EVT_COP_UNUSABLE 1
`define CMU_EVT_UNIMPL 2
`define CMU_EVT_MOVE_DONE 3
`define CMU_EVT_W 4
`define CMU_MASK_RESET 4'h0

// ---------------------------------------------------------------
// Exception codes on the result port
// ---------------------------------------------------------------
`define CMU_EXC_NONE 2'h0
`define CMU_EXC_RESERVED 2'h1
`define CMU_EXC_COP_UNUSABLE 2'h2
`define CMU_EXC_UNIMPL 2'h3

`endif

// File: cmu_decode.v
// Instruction decoder of the conditional move unit.
// Assumes a 32-bit instruction word, combinational, same clock as the top.
`include "cmu_consts.vh"

module cmu_decode (
  input wire [31:0] instr,
  input wire fpu_usable,
  output reg int_cond_move,
  output reg int_move_zero,
  output reg int_move_nonzero,
  output reg fp_cond_move,
  output reg fp_move_zero,
  output reg fp_move_nonzero,
  output reg paired_single,
  output reg [1:0] exc_code
);
  wire [5:0] op = instr[`CMU_OP_HI:`CMU_OP_LO];
  wire [5:0] fn = instr[`CMU_FUNC_HI:`CMU_FUNC_LO];
  wire [4:0] fmt = instr[`CMU_SRC_HI:`CMU_SRC_LO];
  wire sa_zero = (instr[`CMU_SA_HI:`CMU_SA_LO] == `CMU_SA_ZERO);
  wire fmt_ok = (fmt == `CMU_FMT_SINGLE) || (fmt == `CMU_FMT_DOUBLE) ||
                (fmt == `CMU_FMT_PAIRED);

  // Field checks, then coprocessor and format checks
  always @* begin
    int_cond_move = 1'b0;
    int_move_zero = 1'b0;
    int_move_nonzero = 1'b0;
    fp_cond_move = 1'b0;
    fp_move_zero = 1'b0;
    fp_move_nonzero = 1'b0;
    paired_single = 1'b0;
    exc_code = `CMU_EXC_NONE;
    if (op == `CMU_OP_SPECIAL && fn == `CMU_FN_CONDMOVE) begin
      if (!sa_zero || instr[`CMU_CC_ZERO_BIT]) begin
        exc_code = `CMU_EXC_RESERVED;
      end else if (!fpu_usable) begin
        exc_code = `CMU_EXC_COP_UNUSABLE;
      end else begin
        int_cond_move = 1'b1;
      end
    end else if (op == `CMU_OP_SPECIAL && fn == `CMU_FN_MOVE_ZERO) begin
      if (sa_zero) begin
        int_move_zero = 1'b1;
      end else begin
        exc_code = `CMU_EXC_RESERVED;
      end
    end else if (op == `CMU_OP_SPECIAL && fn == `CMU_FN_MOVE_NONZERO) begin
      if (sa_zero) begin
        int_move_nonzero = 1'b1;
      end else begin
        exc_code = `CMU_EXC_RESERVED;
      end
    end else if (op == `CMU_OP_COP1 && (fn == `CMU_FFN_CONDMOVE ||
                 fn == `CMU_FFN_MOVE_ZERO || fn == `CMU_FFN_MOVE_NONZERO)) begin
      if (!fpu_usable) begin
        exc_code = `CMU_EXC_COP_UNUSABLE;
      end else if (!fmt_ok) begin
        exc_code = `CMU_EXC_UNIMPL;
      end else begin
        fp_cond_move = (fn == `CMU_FFN_CONDMOVE);
        fp_move_zero = (fn == `CMU_FFN_MOVE_ZERO);
        fp_move_nonzero = (fn == `CMU_FFN_MOVE_NONZERO);
        paired_single = (fmt == `CMU_FMT_PAIRED);
      end
    end
  end
endmodule

// File: cmu_merge.v
// Result merge of the conditional move unit.
// Assumes decoded flags and operands valid in the same cycle.
`include "cmu_consts.vh"

module cmu_merge #(
  parameter GPR_W = 32,
  parameter FPR_W = 64,
  parameter CC_N = 8
) (
  input wire int_cond_move,
  input wire int_move_zero,
  input wire int_move_nonzero,
  input wire fp_cond_move,
  input wire fp_move_zero,
  input wire fp_move_nonzero,
  input wire paired_single,
  input wire true_false_select,
  input wire [2:0] fp_condition_select,
  input wire [CC_N-1:0] cond_codes,
  input wire [GPR_W-1:0] test_value,
  input wire [FPR_W-1:0] float_src,
  input wire [FPR_W-1:0] float_dest,
  output wire gpr_take,
  output wire [FPR_W-1:0] float_result
);
  localparam HALF = FPR_W / 2;

  // Condition code picked by a 3-bit selector
  function cc_pick;
    input [CC_N-1:0] codes;
    input [2:0] sel;
    begin
      cc_pick = codes[sel];
    end
  endfunction

  wire [2:0] sel_hi = fp_condition_select + 3'h1;
  wire cc_lo = cc_pick(cond_codes, fp_condition_select) == true_false_select;
  wire cc_hi = cc_pick(cond_codes, sel_hi) == true_false_select;
  wire test_zero = (test_value == {GPR_W{1'b0}});

  // Integer move gate by condition code or test register
  assign gpr_take = (int_cond_move && cc_lo) ||
                    (int_move_zero && test_zero) ||
                    (int_move_nonzero && !test_zero);

  // Per-half take of source; destination otherwise kept
  wire take_lo = (fp_cond_move && cc_lo) ||
                 (fp_move_zero && test_zero) ||
                 (fp_move_nonzero && !test_zero);
  wire take_hi = paired_single ? ((fp_cond_move && cc_hi) ||
                                  (!fp_cond_move && take_lo)) : take_lo;

  assign float_result = {take_hi ? float_src[FPR_W-1:HALF] : float_dest[FPR_W-1:HALF],
                         take_lo ? float_src[HALF-1:0] : float_dest[HALF-1:0]};
endmodule

// File: cmu_rf_model.sv
// Register file model: answers operands named by the instruction fields.
// Assumes write-back one cycle after issue; integer register 0 stays zero.
module cmu_rf_model (
  input wire clk,
  input wire [31:0] instr,
  input wire gpr_we,
  input wire [4:0] gpr_wa,
  input wire [31:0] gpr_wd,
  input wire fpr_we,
  input wire [4:0] fpr_wa,
  input wire [63:0] fpr_wd,
  output wire [31:0] gpr_src,
  output wire [31:0] gpr_test,
  output wire [63:0] fpr_src,
  output wire [63:0] fpr_dest
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] general_register_file [32];
  logic [63:0] float_register_file [32];
  // Distinct start contents per register
  initial begin
    for (int n = 0; n < 32; n++) begin
      general_register_file[n] = n * 32'h01010101;
      float_register_file[n] = n * 64'h0123456789ABCDEF;
    end
  end
  // Operand read ports
  assign gpr_src = general_register_file[instr[25:21]];
  assign gpr_test = general_register_file[instr[20:16]];
  assign fpr_src = float_register_file[instr[15:11]];
  assign fpr_dest = float_register_file[instr[10:6]];
  // Write-back
  always @(posedge clk) begin
    if (gpr_we && gpr_wa != 5'h00) general_register_file[gpr_wa] <= gpr_wd;
    if (fpr_we) float_register_file[fpr_wa] <= fpr_wd;
  end
endmodule

// File: cmu_top.v
// Conditional move unit: decode, condition test, register write-back,
// exception report and an APB register block with interrupt.
// Assumes operands arrive from register files on REF_CLK with the
// instruction, and a single APB master on the same clock.
//
// Operation
// - Integer fp-true move: SPECIAL, function 000001, select bit one, zeros elsewhere
// - Selected condition code one copies source integer to destination integer
// - Integer fp-true move raises only reserved or coprocessor-unusable exceptions
// - Float fp-true move copies source when code one, else keeps destination
// - Paired halves merge independently under codes CC and CC+1
// - Paired forms in sixteen-register mode give undefined results
// - Integer zero move: SPECIAL, function 001010, shift field zero
// - Integer zero move copies only when test register is zero
// - Float zero move copies when test is zero, else keeps destination
// - Float nonzero move copies when test is nonzero, else keeps destination
// - Select bit zero gives fp-false move, copying when code is zero
`include "cmu_consts.vh"

module cmu_top #(
  parameter GPR_W = 32,
  parameter FPR_W = 64,
  parameter CC_N = 8
) (
  input wire REF_CLK,
  input wire RSTN,
  // Instruction and operands
  input wire INSTR_VALID,
  input wire [31:0] INSTR,
  input wire [GPR_W-1:0] GPR_SRC_DATA,
  input wire [GPR_W-1:0] GPR_TEST_DATA,
  input wire [FPR_W-1:0] FPR_SRC_DATA,
  input wire [FPR_W-1:0] FPR_DEST_DATA,
  input wire [CC_N-1:0] FP_COND_CODES,
  // Write-back and exception
  output reg GPR_WR_EN,
  output reg [4:0] GPR_WR_ADDR,
  output reg [GPR_W-1:0] GPR_WR_DATA,
  output reg FPR_WR_EN,
  output reg [4:0] FPR_WR_ADDR,
  output reg [FPR_W-1:0] FPR_WR_DATA,
  output reg EXC_VALID,
  output reg [1:0] EXC_CODE,
  // APB slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output wire PREADY,
  output reg [31:0] PRDATA,
  output reg PSLVERR,
  output wire IRQ
);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  reg [31:0] ctrl_r;
  reg [`CMU_EVT_W-1:0] status_r;
  reg [`CMU_EVT_W-1:0] status_nxt;
  reg [`CMU_EVT_W-1:0] mask_r;
  reg [31:0] move_count_r;

  wire fpu_usable = ctrl_r[`CMU_CTRL_FPU_USABLE];
  wire fr16_mode = ctrl_r[`CMU_CTRL_FR16_MODE];

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire int_cond_move;
  wire int_move_zero;
  wire int_move_nonzero;
  wire fp_cond_move;
  wire fp_move_zero;
  wire fp_move_nonzero;
  wire paired_single;
  wire [1:0] dec_exc;

  // Opcode and field checks
  cmu_decode u_decode (
    .instr(INSTR),
    .fpu_usable(fpu_usable),
    .int_cond_move(int_cond_move),
    .int_move_zero(int_move_zero),
    .int_move_nonzero(int_move_nonzero),
    .fp_cond_move(fp_cond_move),
    .fp_move_zero(fp_move_zero),
    .fp_move_nonzero(fp_move_nonzero),
    .paired_single(paired_single),
    .exc_code(dec_exc)
  );

  // ---------------------------------------------------------------
  // Condition test and merge
  // ---------------------------------------------------------------
  wire gpr_take;
  wire [FPR_W-1:0] float_result;

  // Condition code, test register and paired-half merge
  cmu_merge #(
    .GPR_W(GPR_W),
    .FPR_W(FPR_W),
    .CC_N(CC_N)
  ) u_merge (
    .int_cond_move(int_cond_move),
    .int_move_zero(int_move_zero),
    .int_move_nonzero(int_move_nonzero),
    .fp_cond_move(fp_cond_move),
    .fp_move_zero(fp_move_zero),
    .fp_move_nonzero(fp_move_nonzero),
    .paired_single(paired_single),
    .true_false_select(INSTR[`CMU_TF_BIT]),
    .fp_condition_select(INSTR[`CMU_CC_HI:`CMU_CC_LO]),
    .cond_codes(FP_COND_CODES),
    .test_value(GPR_TEST_DATA),
    .float_src(FPR_SRC_DATA),
    .float_dest(FPR_DEST_DATA),
    .gpr_take(gpr_take),
    .float_result(float_result)
  );

  // Any float form decoded without exception
  wire fp_any = fp_cond_move || fp_move_zero || fp_move_nonzero;
  // Paired form in sixteen-register mode: result left undefined, write held off
  wire fp_write = fp_any && !(paired_single && fr16_mode);
  wire exc_hit = INSTR_VALID && (dec_exc != `CMU_EXC_NONE);
  wire move_hit = INSTR_VALID && (gpr_take || fp_write);

  // ---------------------------------------------------------------
  // Write-back stage
  // ---------------------------------------------------------------
  // One-cycle registered write-back; no write when an exception is taken
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      GPR_WR_EN <= 1'b0;
      GPR_WR_ADDR <= 5'h00;
      GPR_WR_DATA <= {GPR_W{1'b0}};
      FPR_WR_EN <= 1'b0;
      FPR_WR_ADDR <= 5'h00;
      FPR_WR_DATA <= {FPR_W{1'b0}};
      EXC_VALID <= 1'b0;
      EXC_CODE <= `CMU_EXC_NONE;
    end else begin
      GPR_WR_EN <= INSTR_VALID && gpr_take;
      GPR_WR_ADDR <= INSTR[`CMU_DEST_HI:`CMU_DEST_LO];
      GPR_WR_DATA <= GPR_SRC_DATA;
      FPR_WR_EN <= INSTR_VALID && fp_write;
      FPR_WR_ADDR <= INSTR[`CMU_SA_HI:`CMU_SA_LO];
      FPR_WR_DATA <= float_result;
      EXC_VALID <= exc_hit;
      EXC_CODE <= INSTR_VALID ? dec_exc : `CMU_EXC_NONE;
    end
  end

  // ---------------------------------------------------------------
  // APB access decode
  // ---------------------------------------------------------------
  wire apb_access = PSEL && PENABLE;
  wire apb_wr = apb_access && PWRITE;
  wire apb_rd = apb_access && !PWRITE;
  wire hit_ctrl = (PADDR == `CMU_REG_CTRL);
  wire hit_status = (PADDR == `CMU_REG_STATUS);
  wire hit_mask = (PADDR == `CMU_REG_MASK);
  wire hit_count = (PADDR == `CMU_REG_COUNT);
  wire hit_any = hit_ctrl || hit_status || hit_mask || hit_count;

  // Zero wait state slave
  assign PREADY = 1'b1;

  // Control and mask writes
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_r <= `CMU_CTRL_RESET;
      mask_r <= `CMU_MASK_RESET;
    end else begin
      if (apb_wr && hit_ctrl) begin
        ctrl_r <= {30'h00000000, PWDATA[1:0]};
      end
      if (apb_wr && hit_mask) begin
        mask_r <= PWDATA[`CMU_EVT_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Event status, clear on read, set wins
  // ---------------------------------------------------------------
  reg [`CMU_EVT_W-1:0] evt_set;

  // Events of this cycle
  always @* begin
    evt_set = {`CMU_EVT_W{1'b0}};
    evt_set[`CMU_EVT_RESERVED] = exc_hit && (dec_exc == `CMU_EXC_RESERVED);
    evt_set[`CMU_EVT_COP_UNUSABLE] = exc_hit && (dec_exc == `CMU_EXC_COP_UNUSABLE);
    evt_set[`CMU_EVT_UNIMPL] = exc_hit && (dec_exc == `CMU_EXC_UNIMPL);
    evt_set[`CMU_EVT_MOVE_DONE] = move_hit;
  end

  // Next status: read clears, a new event in the same cycle stays set
  always @* begin
    if (apb_rd && hit_status) begin
      status_nxt = evt_set;
    end else begin
      status_nxt = status_r | evt_set;
    end
  end

  // Status and move counter
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      status_r <= {`CMU_EVT_W{1'b0}};
      move_count_r <= 32'h00000000;
    end else begin
      status_r <= status_nxt;
      if (move_hit) begin
        move_count_r <= move_count_r + 32'h00000001;
      end
    end
  end

  // Level interrupt from unmasked status
  assign IRQ = |(status_r & mask_r);

  // ---------------------------------------------------------------
  // Read data and error response
  // ---------------------------------------------------------------
  // Read mux; unmapped address answers zero with error
  always @* begin
    PRDATA = 32'h00000000;
    PSLVERR = 1'b0;
    if (apb_access) begin
      if (hit_ctrl) begin
        PRDATA = ctrl_r;
      end else if (hit_status) begin
        PRDATA = {28'h0000000, status_r};
      end else if (hit_mask) begin
        PRDATA = {28'h0000000, mask_r};
      end else if (hit_count) begin
        PRDATA = move_count_r;
      end else begin
        PSLVERR = !hit_any;
      end
    end
  end

endmodule

// File: tb_top.sv
// Bench of the conditional move unit: instruction stream, APB and interrupt.
// Assumes cmu_rf_model as operand source and cmu_assertions bound below.
`include "cmu_consts.vh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic REF_CLK = 0, RSTN = 0, INSTR_VALID = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [31:0] INSTR = 0, PWDATA = 0, x, r;
  logic [11:0] PADDR = 0;
  logic [7:0] FP_COND_CODES = 0;
  wire [31:0] GPR_SRC_DATA, GPR_TEST_DATA, GPR_WR_DATA, PRDATA;
  wire [63:0] FPR_SRC_DATA, FPR_DEST_DATA, FPR_WR_DATA;
  wire [4:0] GPR_WR_ADDR, FPR_WR_ADDR;
  wire [1:0] EXC_CODE;
  wire GPR_WR_EN, FPR_WR_EN, EXC_VALID, PREADY, PSLVERR, IRQ;
  logic [110:0] notes[$];
  logic [4:0] fmts [3] = '{`CMU_FMT_SINGLE, `CMU_FMT_DOUBLE, `CMU_FMT_PAIRED};
  logic e, fpu_on = 1, fr16 = 0;
  int n_errors = 0, num_checks = 0, seed = 51456, k, n_moves = 0;
  cmu_top uut (.REF_CLK, .RSTN, .INSTR_VALID, .INSTR, .GPR_SRC_DATA, .GPR_TEST_DATA,
    .FPR_SRC_DATA, .FPR_DEST_DATA, .FP_COND_CODES, .GPR_WR_EN, .GPR_WR_ADDR, .GPR_WR_DATA,
    .FPR_WR_EN, .FPR_WR_ADDR, .FPR_WR_DATA, .EXC_VALID, .EXC_CODE, .PSEL, .PENABLE, .PWRITE,
    .PADDR, .PWDATA, .PREADY, .PRDATA, .PSLVERR, .IRQ);
  cmu_rf_model rf (.clk(REF_CLK), .instr(INSTR), .gpr_we(GPR_WR_EN), .gpr_wa(GPR_WR_ADDR),
    .gpr_wd(GPR_WR_DATA), .fpr_we(FPR_WR_EN), .fpr_wa(FPR_WR_ADDR), .fpr_wd(FPR_WR_DATA),
    .gpr_src(GPR_SRC_DATA), .gpr_test(GPR_TEST_DATA), .fpr_src(FPR_SRC_DATA),
    .fpr_dest(FPR_DEST_DATA));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial forever #4 REF_CLK = ~REF_CLK;
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [110:0] pk(input logic g, input logic [4:0] ga,
    input logic [31:0] gd, input logic f, input logic [4:0] fa, input logic [63:0] fd,
    input logic v, input logic [1:0] c);
    return {g, g ? ga : 5'h00, g ? gd : 32'h0, f, f ? fa : 5'h00, f ? fd : 64'h0, v, v ? c : 2'h0};
  endfunction
  // Expected result of one instruction, with a flag for whether one appears
  function automatic logic [111:0] predict(input logic [31:0] i);
    logic tk, hi;
    logic [63:0] v;
    tk = FP_COND_CODES[i[20:18]] == i[16];
    if (i[5:1] == 5'h05 || i[5:1] == 5'h09) tk = (GPR_TEST_DATA == 0) ^ i[0];
    hi = tk;
    if (i[25:21] == `CMU_FMT_PAIRED && i[5:0] == 6'h11) begin
      hi = FP_COND_CODES[3'(i[20:18] + 3'h1)] == i[16];
    end
    if (i[31:26] == 6'h00) begin
      if (i[5:0] == 6'h01 && i[17]) return {1'b1, pk(0, 0, 0, 0, 0, 0, 1, 1)};
      if (i[5:0] == 6'h01 && !fpu_on) return {1'b1, pk(0, 0, 0, 0, 0, 0, 1, 2)};
      if (i[10:6] != 0) return {1'b1, pk(0, 0, 0, 0, 0, 0, 1, 1)};
      return {tk, pk(tk, i[15:11], GPR_SRC_DATA, 0, 0, 0, 0, 0)};
    end
    if (!fpu_on) return {1'b1, pk(0, 0, 0, 0, 0, 0, 1, 2)};
    if (i[25:21] == 5'h14) return {1'b1, pk(0, 0, 0, 0, 0, 0, 1, 3)};
    if (fr16 && i[25:21] == `CMU_FMT_PAIRED) return 0;
    v[63:32] = hi ? FPR_SRC_DATA[63:32] : FPR_DEST_DATA[63:32];
    v[31:0] = tk ? FPR_SRC_DATA[31:0] : FPR_DEST_DATA[31:0];
    return {1'b1, pk(0, 0, 0, 1, i[10:6], v, 0, 0)};
  endfunction
  task automatic issue(input logic [31:0] i);
    logic [111:0] p;
    @(posedge REF_CLK);
    INSTR_VALID <= 1;
    INSTR <= i;
    FP_COND_CODES <= $random(seed);
    #1;
    p = predict(i);
    if (p[111]) notes.push_back(p[110:0]);
    if (p[111] && (p[110] || p[72])) n_moves++;
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge REF_CLK);
      INSTR_VALID <= 0;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge REF_CLK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1;
    for (t = 0; t < 16; t++) begin
      @(posedge REF_CLK);
      if (PREADY === 1'b1) break;
    end
    if (t == 16) begin
      n_errors++;
      end_of_test;
    end
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic ee);
    apb(0, a, 0);
    check(r, ed);
    check(e, ee);
  endtask
  // ----------------------------------------
  // Result watcher: pairs each result with the oldest note
  // ----------------------------------------
  always @(posedge REF_CLK) begin
    if (RSTN === 1'b1 && (GPR_WR_EN !== 1'b0 || FPR_WR_EN !== 1'b0 || EXC_VALID !== 1'b0)) begin
      check(pk(GPR_WR_EN, GPR_WR_ADDR, GPR_WR_DATA, FPR_WR_EN, FPR_WR_ADDR, FPR_WR_DATA,
        EXC_VALID, EXC_CODE), notes.size() > 0 ? notes.pop_front() : 111'h0);
    end
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge REF_CLK);
    RSTN <= 1;
    rd(`CMU_REG_CTRL, 1, 0);
    rd(`CMU_REG_MASK, 0, 0);
    rd(`CMU_REG_COUNT, 0, 0);
    rd(`CMU_REG_STATUS, 0, 0);
    rd(12'h010, 0, 1);
    apb(1, `CMU_REG_MASK, 32'h8);
    for (k = 0; k < 16; k++) begin
      x = $random(seed);
      issue({6'h00, x[25:21], k[2:0], 1'b0, k[3], x[15:11], 5'h00, 6'h01});
      issue({6'h00, x[25:21], k[0] ? x[20:16] : 5'h00, x[15:11], 5'h00, 5'h05, k[1]});
    end
    for (k = 0; k < 45; k++) begin
      x = $random(seed);
      x[18:17] = 2'h0;
      if (k % 4 == 0) x[20:16] = 5'h00;
      issue({6'h11, fmts[k % 3], x[20:6], 6'h11 + 6'(k / 3 % 3)});
    end
    issue({6'h00, 5'h01, 3'h0, 2'h3, 5'h02, 5'h00, 6'h01});
    issue({6'h00, 5'h01, 5'h00, 5'h02, 5'h01, 6'h0A});
    issue({6'h11, 5'h14, 5'h00, 5'h01, 5'h02, 6'h12});
    idle(3);
    check(IRQ, 1);
    rd(`CMU_REG_COUNT, n_moves, 0);
    rd(`CMU_REG_STATUS, 32'hD, 0);
    idle(2);
    check(IRQ, 0);
    apb(1, `CMU_REG_CTRL, 0);
    apb(1, `CMU_REG_MASK, 32'h2);
    fpu_on = 0;
    issue({6'h00, 5'h03, 3'h1, 2'h1, 5'h04, 5'h00, 6'h01});
    issue({6'h11, `CMU_FMT_DOUBLE, 5'h00, 5'h01, 5'h02, 6'h12});
    idle(3);
    check(IRQ, 1);
    rd(`CMU_REG_STATUS, 32'h2, 0);
    apb(1, `CMU_REG_CTRL, 32'h3);
    rd(`CMU_REG_CTRL, 32'h3, 0);
    fpu_on = 1;
    fr16 = 1;
    issue({6'h11, `CMU_FMT_PAIRED, 5'h00, 5'h01, 5'h02, 6'h12});
    issue({6'h11, `CMU_FMT_SINGLE, 5'h00, 5'h03, 5'h04, 6'h13});
    idle(3);
    check(notes.size(), 0);
    end_of_test;
  end
endmodule

bind cmu_top cmu_assertions #(.GPR_W(GPR_W), .FPR_W(FPR_W), .CC_N(CC_N)) chk (.REF_CLK, .RSTN,
  .INSTR_VALID, .INSTR, .GPR_SRC_DATA, .GPR_TEST_DATA, .FPR_SRC_DATA, .FPR_DEST_DATA,
  .FP_COND_CODES, .GPR_WR_EN, .GPR_WR_ADDR, .GPR_WR_DATA, .FPR_WR_EN, .FPR_WR_DATA,
  .EXC_VALID, .EXC_CODE);
